// file: core/vcs_segmenter.sv
// Virtual channel layer: per-channel buffers, segmentation, credit flow control.
//
// Overview of operation
// - Cut each output buffer's data into frames of at most 256 characters.
// - Offer a channel only once it holds 256 characters or a packet end.
// - Output buffers accept characters and packet-end markers first in, first out.
// - Input buffers give received characters and packet-end markers first in, first out.
// - Each input buffer holds at least one full 256-character frame.
// - Received frame contents of each channel go in order to its input buffer.
// - Send a credit token whenever an input buffer gains room for 256 more characters.
// - Received credit tokens tell the access controller which channels may send.
// - One input buffer and one output buffer exist for every channel.
// - A channel competes only with buffered data and far-end room for a frame.
// - Credit tokens are held until the protected outbound path takes them.
// - Frames from different channels interleave on the link frame by frame.
// - The next eligible channel in rotating order after the last one served sends a frame of up to 256 characters.
`include "vcs_map.svh"
module vcs_segmenter (
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic [`VCS_NUM_VC-1:0]  app_tx_wr,
  input  wire vcs_pkg::vcs_char_t      app_tx_char [`VCS_NUM_VC],
  output logic [`VCS_NUM_VC-1:0]       app_tx_full,
  input  wire logic [`VCS_NUM_VC-1:0]  app_rx_rd,
  output vcs_pkg::vcs_char_t           app_rx_char [`VCS_NUM_VC],
  output logic [`VCS_NUM_VC-1:0]       app_rx_empty,
  output logic                         frm_tx_valid,
  input  wire logic                    frm_tx_ready,
  output logic [`VCS_VC_W-1:0]         frm_tx_vc,
  output vcs_pkg::vcs_char_t           frm_tx_char,
  output logic                         frm_tx_first,
  output logic                         frm_tx_last,
  input  wire logic                    frm_rx_valid,
  input  wire logic [`VCS_VC_W-1:0]    frm_rx_vc,
  input  wire vcs_pkg::vcs_char_t      frm_rx_char,
  input  wire logic                    tok_rx_valid,
  input  wire logic [`VCS_VC_W-1:0]    tok_rx_vc,
  output logic                         tok_tx_valid,
  input  wire logic                    tok_tx_ready,
  output logic [`VCS_VC_W-1:0]         tok_tx_vc
);
  localparam int NVC = `VCS_NUM_VC;

  vcs_pkg::vcs_mac_state_t     state;
  vcs_pkg::vcs_char_t          ob_char [NVC];
  logic [`VCS_CNT_W-1:0]       ob_cnt [NVC];
  logic [`VCS_CNT_W-1:0]       ob_eops [NVC];
  logic [`VCS_CNT_W-1:0]       ib_cnt [NVC];
  logic [`VCS_CNT_W-1:0]       promised [NVC];
  logic [`VCS_CREDIT_W-1:0]    credit [NVC];
  logic [NVC-1:0]              ob_empty;
  logic [NVC-1:0]              ib_full;
  logic [NVC-1:0]              ib_wr;
  logic [NVC-1:0]              eligible;
  logic [NVC-1:0]              tok_need;
  logic [`VCS_VC_W-1:0]        cur_vc;
  logic [`VCS_VC_W-1:0]        rr_last;
  logic [`VCS_VC_W-1:0]        pick;
  logic [`VCS_VC_W-1:0]        tok_pick;
  logic [`VCS_LEN_W-1:0]       sent;
  logic                        adv;
  logic                        start;
  logic                        pop;
  logic                        cur_last;
  logic                        tok_issue;

  // Rotating choice: the first requester after the last one served wins.
  function automatic logic [`VCS_VC_W-1:0] rr_pick(input logic [NVC-1:0] mask,
                                                   input logic [`VCS_VC_W-1:0] last);
    logic [`VCS_VC_W-1:0] res;
    logic                 found;
    int                   idx;
    res   = last;
    found = 1'b0;
    for (int i = 1; i <= NVC; i++)
    begin
      idx = (int'(last) + i) % NVC;
      if (!found && mask[idx])
      begin
        res   = idx[`VCS_VC_W-1:0];
        found = 1'b1;
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Per-channel buffers and counters
  // ----------------------------------------------------------------
  // One output and one input buffer per channel.
  for (genvar v = 0; v < NVC; v++)
  begin : g_vc
    logic ob_pop;
    logic ob_wr;
    assign ob_wr    = app_tx_wr[v] & ~app_tx_full[v];
    assign ob_pop   = pop & (cur_vc == v);
    assign ib_wr[v] = frm_rx_valid & (frm_rx_vc == v);
    // Ready once credit is held and a whole frame, or a complete packet, is buffered.
    assign eligible[v] = (credit[v] != '0) &
                         ((ob_cnt[v] >= `VCS_CNT_W'(`VCS_FRAME_MAX)) | (ob_eops[v] != '0));
    // Room for another frame beyond what is already promised.
    assign tok_need[v] = ({1'b0, ib_cnt[v]} + {1'b0, promised[v]}) <=
                         (`VCS_CNT_W+1)'(`VCS_BUF_DEPTH - `VCS_FRAME_MAX);

    // Output buffer with a write side for characters and markers.
    vcs_fifo u_obuf (
      .clk     (clk),
      .sys_rst (sys_rst),
      .wr_en   (app_tx_wr[v]),
      .wr_char (app_tx_char[v]),
      .rd_en   (ob_pop),
      .rd_char (ob_char[v]),
      .count   (ob_cnt[v]),
      .full    (app_tx_full[v]),
      .empty   (ob_empty[v])
    );

    // Input buffer of 512 characters with a read side.
    vcs_fifo u_ibuf (
      .clk     (clk),
      .sys_rst (sys_rst),
      .wr_en   (ib_wr[v]),
      .wr_char (frm_rx_char),
      .rd_en   (app_rx_rd[v]),
      .rd_char (app_rx_char[v]),
      .count   (ib_cnt[v]),
      .full    (ib_full[v]),
      .empty   (app_rx_empty[v])
    );

    // Packet ends held, credits held and space already promised to the far end.
    always_ff @(posedge clk)
    begin
      if (sys_rst)
      begin
        ob_eops[v]  <= '0;
        credit[v]   <= '0;
        promised[v] <= '0;
      end
      else
      begin
        ob_eops[v] <= ob_eops[v]
                      + {{(`VCS_CNT_W-1){1'b0}}, ob_wr & app_tx_char[v][`VCS_EOP_BIT]}
                      - {{(`VCS_CNT_W-1){1'b0}}, ob_pop & ob_char[v][`VCS_EOP_BIT]};
        // Token adds one frame of credit unless credit is at its maximum, a frame start uses one.
        credit[v] <= credit[v]
                     + {{(`VCS_CREDIT_W-1){1'b0}},
                        tok_rx_valid & (tok_rx_vc == v) & (credit[v] != `VCS_CREDIT_MAX)}
                     - {{(`VCS_CREDIT_W-1){1'b0}}, start & (pick == v)};
        // Each arriving character uses up one promised place while any promised place is left.
        promised[v] <= promised[v]
                       + ((tok_issue && tok_pick == v) ? `VCS_CNT_W'(`VCS_FRAME_MAX) : '0)
                       - {{(`VCS_CNT_W-1){1'b0}}, ib_wr[v] & (promised[v] != '0)};
      end
    end
  end

  // ----------------------------------------------------------------
  // Medium access control and segmentation
  // ----------------------------------------------------------------
  // Frame starts on a granted channel; a character moves when the slot is free.
  assign adv      = ~frm_tx_valid | frm_tx_ready;
  assign pick     = rr_pick(eligible, rr_last);
  assign start    = (state == vcs_pkg::VCS_IDLE) & (|eligible);
  assign pop      = (state == vcs_pkg::VCS_SEND) & adv & ~ob_empty[cur_vc];
  assign cur_last = (sent == `VCS_FRAME_LAST) | (ob_cnt[cur_vc] == `VCS_CNT_W'(1));

  // Frame state: one channel owns the link until its frame ends.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state   <= vcs_pkg::VCS_IDLE;
      cur_vc  <= '0;
      rr_last <= '0;
      sent    <= '0;
    end
    else
    begin
      case (state)
        vcs_pkg::VCS_IDLE:
        begin
          if (start)
          begin
            state   <= vcs_pkg::VCS_SEND;
            cur_vc  <= pick;
            rr_last <= pick;
            sent    <= '0;
          end
        end
        vcs_pkg::VCS_SEND:
        begin
          if (pop)
          begin
            sent <= sent + `VCS_LEN_W'(1);
            if (cur_last)
              state <= vcs_pkg::VCS_IDLE;
          end
        end
        default: state <= vcs_pkg::VCS_IDLE;
      endcase
    end
  end

  // Outbound character register toward the framing layer.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      frm_tx_valid <= 1'b0;
      frm_tx_vc    <= '0;
      frm_tx_char  <= '0;
      frm_tx_first <= 1'b0;
      frm_tx_last  <= 1'b0;
    end
    else if (pop)
    begin
      frm_tx_valid <= 1'b1;
      frm_tx_vc    <= cur_vc;
      frm_tx_char  <= ob_char[cur_vc];
      frm_tx_first <= (sent == '0);
      frm_tx_last  <= cur_last;
    end
    else if (frm_tx_ready)
      frm_tx_valid <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Credit token sender
  // ----------------------------------------------------------------
  // A token is held until taken, so the protected path never misses one.
  assign tok_pick  = rr_pick(tok_need, tok_tx_vc);
  assign tok_issue = (~tok_tx_valid | tok_tx_ready) & (|tok_need);

  // Token register.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      tok_tx_valid <= 1'b0;
      tok_tx_vc    <= '0;
    end
    else if (tok_issue)
    begin
      tok_tx_valid <= 1'b1;
      tok_tx_vc    <= tok_pick;
    end
    else if (tok_tx_ready)
      tok_tx_valid <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  frame_end_a: assert property (
    (pop && sent == `VCS_FRAME_LAST) |=> state == vcs_pkg::VCS_IDLE && frm_tx_last)
    else $error("frame ran past 256 characters");
  frame_first_a: assert property ((pop && sent == '0) |=> frm_tx_valid && frm_tx_first)
    else $error("first character not marked");
  offer_size_a: assert property (
    start |-> (ob_cnt[pick] >= `VCS_CNT_W'(`VCS_FRAME_MAX)) || (ob_eops[pick] != '0))
    else $error("channel offered before a frame or packet end was buffered");
  credit_need_a: assert property (start |-> credit[pick] != '0 && !ob_empty[pick])
    else $error("frame started without credit or data");
  credit_gain_a: assert property (
    (tok_rx_valid && tok_rx_vc == '0 && !(start && pick == '0) && credit[0] != `VCS_CREDIT_MAX)
    |=> credit[0] == $past(credit[0]) + 8'h01)
    else $error("received token did not add one credit");
  credit_use_a: assert property (
    (start && pick == '0 && !tok_rx_valid) |=> credit[0] == $past(credit[0]) - 8'h01)
    else $error("frame start did not use one credit");
  tok_hold_a: assert property (
    (tok_tx_valid && !tok_tx_ready) |=> tok_tx_valid && $stable(tok_tx_vc))
    else $error("credit token dropped before it was taken");
  tok_room_a: assert property (
    ({1'b0, ib_cnt[0]} + {1'b0, promised[0]}) <= (`VCS_CNT_W+1)'(`VCS_BUF_DEPTH))
    else $error("more space promised than the input buffer holds");
  out_hold_a: assert property (
    (frm_tx_valid && !frm_tx_ready) |=> frm_tx_valid && $stable(frm_tx_char) && $stable(frm_tx_vc))
    else $error("outbound character changed while stalled");
  rx_store_a: assert property (
    (ib_wr[0] && !ib_full[0] && !app_rx_rd[0]) |=> ib_cnt[0] == $past(ib_cnt[0]) + 10'h001)
    else $error("received character not stored");

  full_frame_c: cover property (pop && sent == `VCS_FRAME_LAST);
  interleave_c: cover property ((start && pick == 1'b1) ##[1:600] (start && pick == '0));
  token_sent_c: cover property (tok_tx_valid && tok_tx_ready);
  stall_c: cover property (frm_tx_valid && !frm_tx_ready ##1 frm_tx_ready);
endmodule

// file: core/vcs_map.svh
// Constants of the virtual channel segmenter: sizes, widths and count limits.
`ifndef VCS_MAP_SVH
`define VCS_MAP_SVH

`define VCS_NUM_VC     2
`define VCS_VC_W       1
`define VCS_CHAR_W     9
`define VCS_EOP_BIT    8
`define VCS_FRAME_MAX  256
`define VCS_FRAME_LAST 8'hFF
`define VCS_LEN_W      8
`define VCS_BUF_DEPTH  512
`define VCS_ADDR_W     9
`define VCS_CNT_W      10
`define VCS_CREDIT_W   8
`define VCS_CREDIT_MAX 8'hFF

`endif

// file: core/vcs_pkg.sv
// Types shared by the virtual channel segmenter files.
package vcs_pkg;
  typedef logic [8:0] vcs_char_t;
  typedef enum logic {VCS_IDLE, VCS_SEND} vcs_mac_state_t;
endpackage

// file: core/vcs_fifo.sv
// Character buffer with first-in first-out write and read sides.
`include "vcs_map.svh"
module vcs_fifo (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  wr_en,
  input  wire vcs_pkg::vcs_char_t    wr_char,
  input  wire logic                  rd_en,
  output vcs_pkg::vcs_char_t         rd_char,
  output logic [`VCS_CNT_W-1:0]      count,
  output logic                       full,
  output logic                       empty
);
  vcs_pkg::vcs_char_t       mem [`VCS_BUF_DEPTH];
  logic [`VCS_ADDR_W-1:0]   wr_ptr;
  logic [`VCS_ADDR_W-1:0]   rd_ptr;
  logic [`VCS_CNT_W-1:0]    next_count;
  logic                     do_wr;
  logic                     do_rd;

  // Writes to a full buffer and reads from an empty one are ignored.
  assign do_wr      = wr_en & ~full;
  assign do_rd      = rd_en & ~empty;
  assign rd_char    = mem[rd_ptr];
  assign next_count = count + {{(`VCS_CNT_W-1){1'b0}}, do_wr} - {{(`VCS_CNT_W-1){1'b0}}, do_rd};

  // Storage array carries no reset.
  always_ff @(posedge clk)
  begin
    if (do_wr)
      mem[wr_ptr] <= wr_char;
  end

  // Pointers and flags are registered so that full and empty come from flops.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
      full   <= 1'b0;
      empty  <= 1'b1;
    end
    else
    begin
      wr_ptr <= wr_ptr + {{(`VCS_ADDR_W-1){1'b0}}, do_wr};
      rd_ptr <= rd_ptr + {{(`VCS_ADDR_W-1){1'b0}}, do_rd};
      count  <= next_count;
      full   <= (next_count == `VCS_CNT_W'(`VCS_BUF_DEPTH));
      empty  <= (next_count == '0);
    end
  end
endmodule

// file: sim/vcs_far_end.sv
// Far-end model: the framing layer's ready handshakes, with random stalls.
module vcs_far_end (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic slow,
  output logic      frm_tx_ready,
  output logic      tok_tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;

  // Ready is random; slow mode holds frm_tx_ready low most cycles so the sender must wait.
  always @(posedge clk)
  begin
    frm_tx_ready <= !sys_rst && (slow ? ($urandom % 4 == 0) : ($urandom % 4 != 0));
    tok_tx_ready <= !sys_rst && ($urandom % 2 == 1);
  end
endmodule

// file: sim/tb.sv
// Self-checking testbench of the virtual channel segmenter.
`include "vcs_map.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clk = 0, sys_rst = 1, slow = 0, rd_on = 0;
  logic [1:0]         app_tx_wr = 0, app_rx_rd = 0, app_tx_full, app_rx_empty;
  vcs_pkg::vcs_char_t app_tx_char [2] = '{default: '0};
  vcs_pkg::vcs_char_t app_rx_char [2];
  logic               frm_tx_valid, frm_tx_ready, frm_tx_first, frm_tx_last;
  logic               tok_tx_valid, tok_tx_ready, frm_rx_valid = 0, tok_rx_valid = 0;
  logic [0:0]         frm_tx_vc, tok_tx_vc, frm_rx_vc = 0, tok_rx_vc = 0;
  vcs_pkg::vcs_char_t frm_tx_char, frm_rx_char = 0;
  vcs_pkg::vcs_char_t exp_tx [2][$], hold_tx [2][$], exp_rx [2][$];
  logic [0:0]         exp_tok [$], frm_seq [$];
  logic               in_frm = 0, exp_last;
  int                 n_fail = 0, comparisons = 0, flen = 0;

  always #4 clk = ~clk;

  vcs_segmenter u_vcs_segmenter (.clk, .sys_rst, .app_tx_wr, .app_tx_char, .app_tx_full,
    .app_rx_rd, .app_rx_char, .app_rx_empty, .frm_tx_valid, .frm_tx_ready, .frm_tx_vc,
    .frm_tx_char, .frm_tx_first, .frm_tx_last, .frm_rx_valid, .frm_rx_vc, .frm_rx_char,
    .tok_rx_valid, .tok_rx_vc, .tok_tx_valid, .tok_tx_ready, .tok_tx_vc);
  vcs_far_end u_vcs_far_end (.clk, .sys_rst, .slow, .frm_tx_ready, .tok_tx_ready);

  task automatic cmp_char(string what, vcs_pkg::vcs_char_t e, vcs_pkg::vcs_char_t s);
    comparisons++;
    if (s !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, e, s);
    end
  endtask

  task automatic cmp_bit(string what, logic e, logic s);
    comparisons++;
    if (s !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %b seen %b", what, e, s);
    end
  endtask

  task automatic surplus(string what);
    n_fail++;
    $display("[ERR] %s expected none seen one", what);
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Watcher: takes the oldest note of each kind as a result appears.
  always @(posedge clk)
  begin
    if (!sys_rst && frm_tx_valid && frm_tx_ready)
    begin
      flen = in_frm ? flen + 1 : 1;
      cmp_bit("tx first", !in_frm, frm_tx_first);
      if (!in_frm)
        frm_seq.push_back(frm_tx_vc);
      in_frm = !frm_tx_last;
      if (exp_tx[frm_tx_vc].size() == 0)
        surplus("tx char");
      else
      begin
        cmp_char("tx char", exp_tx[frm_tx_vc].pop_front(), frm_tx_char);
        exp_last = hold_tx[frm_tx_vc].size() + exp_tx[frm_tx_vc].size() == 0;
        cmp_bit("tx last", exp_last || flen == `VCS_FRAME_MAX, frm_tx_last);
      end
    end
    if (!sys_rst && tok_tx_valid && tok_tx_ready)
    begin
      if (exp_tok.size() == 0)
        surplus("token");
      else
        cmp_bit("token vc", exp_tok.pop_front(), tok_tx_vc);
    end
    for (int v = 0; v < 2; v++)
      if (!sys_rst && app_rx_rd[v] && !app_rx_empty[v])
      begin
        if (exp_rx[v].size() == 0)
          surplus("rx char");
        else
          cmp_char("rx char", exp_rx[v].pop_front(), app_rx_char[v]);
      end
    app_rx_rd <= rd_on ? 2'($urandom) : 2'b00;
  end

  // Loads one packet: n random characters, the last one carrying the end mark.
  task send_pkt(int v, int n);
    vcs_pkg::vcs_char_t c;
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      c = {i == n - 1, 8'($urandom)};
      app_tx_wr[v] <= 1'b1;
      app_tx_char[v] <= c;
      hold_tx[v].push_back(c);
    end
    @(posedge clk);
    app_tx_wr[v] <= 1'b0;
  endtask

  task give_tok(int v);
    @(posedge clk);
    tok_rx_valid <= 1'b1;
    tok_rx_vc <= 1'(v);
    @(posedge clk);
    tok_rx_valid <= 1'b0;
  endtask

  // Lets n held characters go out and grants one frame of credit, which covers up to 256 of them.
  task release_chars(int v, int n);
    repeat (n) exp_tx[v].push_back(hold_tx[v].pop_front());
    give_tok(v);
  endtask

  task recv(int v, int n);
    vcs_pkg::vcs_char_t c;
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      c = 9'($urandom);
      frm_rx_valid <= 1'b1;
      frm_rx_vc <= 1'(v);
      frm_rx_char <= c;
      exp_rx[v].push_back(c);
    end
    @(posedge clk);
    frm_rx_valid <= 1'b0;
    frm_rx_char <= ~c;
  endtask

  task wait_drain(int limit);
    int k;
    for (k = 0; k < limit; k++)
    begin
      @(posedge clk);
      if (exp_tx[0].size() + exp_tx[1].size() + exp_rx[0].size() + exp_rx[1].size()
          + exp_tok.size() == 0)
        break;
    end
    if (k == limit)
    begin
      n_fail++;
      $display("[ERR] drain wait expected done seen timeout");
      give_verdict();
    end
  endtask

  initial
  begin
    void'($urandom(55));
    exp_tok = '{1'b1, 1'b0, 1'b1, 1'b0};
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    wait_drain(200);
    $display("test reset tokens done");
    send_pkt(0, 300);
    repeat (40) @(posedge clk);
    release_chars(0, 256);
    wait_drain(2000);
    repeat (100) @(posedge clk);
    release_chars(0, 44);
    wait_drain(2000);
    $display("test credit segmenting done");
    send_pkt(1, 512);
    @(negedge clk);
    cmp_bit("tx full", 1'b1, app_tx_full[1]);
    release_chars(1, 512);
    give_tok(1);
    wait_drain(3000);
    $display("test full buffer done");
    slow <= 1'b1;
    frm_seq.delete();
    send_pkt(0, 300);
    send_pkt(1, 20);
    release_chars(0, 300);
    give_tok(0);
    release_chars(1, 20);
    wait_drain(4000);
    cmp_bit("frame count", 1'b1, frm_seq.size() == 3);
    cmp_bit("frame order", 1'b1, frm_seq[1]);
    $display("test interleave done");
    exp_tok.push_back(1'b0);
    recv(0, 256);
    recv(1, 10);
    rd_on <= 1'b1;
    wait_drain(4000);
    $display("test receive done");
    give_verdict();
  end
endmodule
